// *** design/adc_conv_pkg.sv ***
// Shared constants, timing figures and signal bundles of the converter control block
package adc_conv_pkg;

	// Result word and edge counter widths
	localparam int RESULT_BITS      = 16;
	localparam int COUNT_BITS       = 5;

	// Conversion sequence counted in conversion-clock rising edges
	localparam logic [4:0] FIRST_EDGE     = 5'h01;
	localparam logic [4:0] LAST_BIT_EDGE  = 5'h10;
	localparam int         LATCH_EDGE_NUM = 17;
	localparam int         CYCLE_CONV_CLKS = 20;
	localparam int         CONVERT_CLKS   = 16;
	localparam logic [2:0] ACQ_CLKS       = 3'(CYCLE_CONV_CLKS - CONVERT_CLKS);

	// Timing figures and the cycle counts derived from them
	localparam int CLK_PERIOD_NS      = 10;
	localparam int BUSY_DELAY_MAX_NS  = 25;
	localparam int HOLD_DELAY_MAX_NS  = 10;
	localparam int BUSY_DELAY_MAX_CYC = (BUSY_DELAY_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
		BUSY_DELAY_MAX_NS / CLK_PERIOD_NS;
	localparam int HOLD_DELAY_MAX_CYC = (HOLD_DELAY_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
		HOLD_DELAY_MAX_NS / CLK_PERIOD_NS;

	// Values after reset, and the trial code loaded when a conversion begins
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [15:0] SAR_RESET    = 16'h0000;
	localparam logic [15:0] SAR_FIRST    = 16'h8000;
	localparam logic [4:0]  COUNT_RESET  = 5'h00;
	localparam logic [2:0]  ACQ_RESET    = 3'h0;

	// Host-side strobes, all active low except the byte-half select
	typedef struct packed {
		logic conversion_start_n;
		logic chip_select_n;
		logic read_n;
		logic byte_high;
	} host_ctrl_s;

	// Parallel data bus towards the pins; en_n low while the block drives
	typedef struct packed {
		logic [15:0] parallel_data_out;
		logic        en_n;
	} data_bus_s;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARMED,
		ST_CONVERT
	} conv_state_e;

endpackage : adc_conv_pkg

// *** design/sar_result_reg.sv ***
// Output register that holds the last latched conversion result
module sar_result_reg #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// Load port
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] d,
	// Stored word
	output logic      [WIDTH-1:0] q
);
	import adc_conv_pkg::*;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			q <= WIDTH'(RESULT_RESET);
		else if (load)
			q <= d;
	end

endmodule : sar_result_reg

// *** design/sar_adc_ctrl.sv ***
// Conversion control, successive approximation and parallel read-out of the converter
//
// Summary of operation
// RL1: Host supplies conversion clock between 25kHz and 10MHz.
// RL2: Conversion clock period at least 100ns, each phase at least 40ns.
// RL3: Busy starts low; reads and sampling never change it.
// RL4: Busy rises within 25ns once a conversion begins, stays high throughout.
// RL5: Result latched on 17th conversion-clock edge, busy falls within 25ns.
// RL6: Byte select low: full 16-bit result on the data lines.
// RL7: Byte select high: result bits 15..8 on the lower eight lines.
// RL8: An 8-bit host reads low byte first, then high byte.
// RL9: Falling conversion start switches sampling to hold within 10ns.
// RL10: Select must be low at start fall; conversion begins next clock rise.
// RL11: Start must fall 10ns before the clock edge it targets.
// RL12: Start held low never retriggers; a fresh fall is needed.
// RL13: Start high and low phases each at least 20ns.
// RL14: Start pulses ignored until the running conversion finishes or reset.
// RL15: After 16 conversion cycles sampling switches close to acquire again.
// RL16: Host waits at least 400ns of sampling before next start.
// RL17: One conversion cycle including acquisition spans 20 clock cycles.
// RL18: Data outputs released unless select and read strobe are both low.
// RL19: Host keeps read and select low 40ns before taking data.
// RL20: Read strobe high at least 20ns between reads.
// RL21: Host avoids reading near a falling conversion start.
// RL22: Results are two's complement, 7FFF top, 8000 bottom, FFFF below zero.
// RL23: Latched result stays stable until the next conversion latches.
module sar_adc_ctrl (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	// Conversion clock from the host, sampled as a plain input
	input  wire logic                    conv_clk,
	// Host strobes
	input  wire adc_conv_pkg::host_ctrl_s host,
	// Analog comparator: high when input lies above the trial code
	input  wire logic                    comparator_high,
	// Analog front end control
	output logic [15:0]                  capacitive_dac,
	output logic                         hold_mode,
	// Status
	output logic                         busy,
	output logic                         acq_ready,
	// Parallel data bus
	output adc_conv_pkg::data_bus_s       bus
);
	import adc_conv_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Declarations

	conv_state_e       state;
	conv_state_e       next_state;
	logic              conv_clk_q;
	logic              start_q;
	logic [4:0]        edge_count;
	logic [2:0]        acq_count;
	logic [15:0]       result;
	logic [15:0]       next_sar;
	logic [15:0]       final_code;
	data_bus_s         next_bus;

	wire  conv_rise;
	wire  start_fall;
	wire  start_accept;
	wire  conv_begin;
	wire  bit_edge;
	wire  latch_now;
	wire  read_active;
	wire  [3:0] bit_idx;

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Keep or drop the trial bit, then try the next lower one
	function automatic logic [15:0] sar_step(input logic [15:0] code, input logic [3:0] idx,
		input logic keep);
		logic [15:0] r;
		r = code;
		if (!keep)
			r[idx] = 1'b0;
		if (idx != 4'h0)
			r[idx - 4'h1] = 1'b1;
		return r;
	endfunction : sar_step

	// Offset binary from the array to two's complement on the bus
	function automatic logic [15:0] to_twos(input logic [15:0] code);
		return {~code[15], code[14:0]};
	endfunction : to_twos

	////////////////////////////////////////////////////////////////////////
	// Decoding

	assign conv_rise    = conv_clk & ~conv_clk_q;
	assign start_fall   = start_q & ~host.conversion_start_n;
	// Further falls are lost while armed or converting, so a held-low start never retriggers
	assign start_accept = start_fall & ~host.chip_select_n & (state == ST_IDLE); // RL10 RL12 RL14
	assign conv_begin   = (state == ST_ARMED) & conv_rise; // RL10
	assign bit_edge     = (state == ST_CONVERT) & conv_rise;
	assign latch_now    = bit_edge & (edge_count == LAST_BIT_EDGE); // RL5
	assign bit_idx      = 4'(COUNT_BITS'(LAST_BIT_EDGE) - edge_count);
	assign next_sar     = sar_step(capacitive_dac, bit_idx, comparator_high);
	assign final_code   = to_twos(next_sar); // RL22
	assign read_active  = ~host.chip_select_n & ~host.read_n;

	// High half goes to the low lanes; the idle upper lanes read zero
	assign next_bus.parallel_data_out = host.byte_high ? {8'h00, result[15:8]} : result; // RL6 RL7
	assign next_bus.en_n              = ~read_active; // RL18

	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:    if (start_accept) next_state = ST_ARMED;
			ST_ARMED:   if (conv_begin)   next_state = ST_CONVERT;
			ST_CONVERT: if (latch_now)    next_state = ST_IDLE; // RL14
			default:    next_state = ST_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencing

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state      <= ST_IDLE;
			conv_clk_q <= 1'b0;
			start_q    <= 1'b1;
		end
		else
		begin
			state      <= next_state;
			conv_clk_q <= conv_clk;
			start_q    <= host.conversion_start_n;
		end
	end

	// Busy follows conversion only; reads and sampling never touch it
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			busy <= 1'b0; // RL3
		else if (conv_begin)
			busy <= 1'b1; // RL4
		else if (latch_now)
			busy <= 1'b0; // RL5
	end

	// Hold engages on the accepted fall, releases when the last bit resolves
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			hold_mode <= 1'b0;
		else if (start_accept)
			hold_mode <= 1'b1; // RL9
		else if (latch_now)
			hold_mode <= 1'b0; // RL15
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			edge_count     <= COUNT_RESET;
			capacitive_dac <= SAR_RESET;
		end
		else if (conv_begin)
		begin
			edge_count     <= FIRST_EDGE;
			capacitive_dac <= SAR_FIRST;
		end
		else if (bit_edge)
		begin
			edge_count     <= edge_count + 5'h01;
			capacitive_dac <= next_sar;
		end
	end

	// Acquisition spans the remaining clocks of the 20-clock cycle
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			acq_count <= ACQ_RESET;
		else if (start_accept || latch_now)
			acq_count <= ACQ_RESET;
		else if (conv_rise && state == ST_IDLE && acq_count != ACQ_CLKS)
			acq_count <= acq_count + 3'h1; // RL17
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			acq_ready <= 1'b0;
		else
			acq_ready <= (state == ST_IDLE) && !latch_now && (acq_count == ACQ_CLKS); // RL17
	end

	// Bus is registered so every pin comes from a flop; costs one cycle of access time
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			bus <= '{parallel_data_out: RESULT_RESET, en_n: 1'b1};
		else
			bus <= next_bus; // RL18
	end

	////////////////////////////////////////////////////////////////////////
	// Result register

	sar_result_reg #(
		.WIDTH (RESULT_BITS)
	) u_result (
		.clk     (clk),
		.reset_n (reset_n),
		.load    (latch_now), // RL5 RL23
		.d       (final_code),
		.q       (result)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks

	// Rises counted apart from the bit counter, begin rise included, so a wrong latch edge shows
	logic [4:0] rise_total;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rise_total <= COUNT_RESET;
		else if (conv_begin)
			rise_total <= FIRST_EDGE;
		else if (conv_rise && busy)
			rise_total <= rise_total + 5'h01;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_busy_after_reset:  assert property ($rose(reset_n) |-> !busy) else $error("busy high after reset"); // RL3
	a_busy_rise_time:    assert property (conv_begin |-> ##[1:2] busy) else $error("busy late"); // RL4
	a_busy_held:         assert property (busy && !latch_now |=> busy) else $error("busy dropped early"); // RL3
	a_busy_fall_time:    assert property (latch_now |-> ##[1:2] !busy) else $error("busy stuck high"); // RL5
	a_latch_on_edge:     assert property (conv_rise && busy |->
		latch_now == (rise_total == 5'(LATCH_EDGE_NUM - 1))) else $error("latch on wrong edge"); // RL5
	a_hold_time:         assert property (start_accept |=> hold_mode) else $error("hold late"); // RL9
	a_hold_release:      assert property (latch_now |=> !hold_mode && !busy) else $error("hold kept"); // RL15
	a_select_needed:     assert property (start_fall && host.chip_select_n && state == ST_IDLE |=> state == ST_IDLE)
		else $error("start without select"); // RL10
	a_ignore_while_busy: assert property (busy && start_fall |=> state == ST_CONVERT || !busy)
		else $error("start taken while busy"); // RL14
	a_no_retrigger:      assert property (state == ST_IDLE && !start_fall |=> state == ST_IDLE)
		else $error("retrigger without fall"); // RL12
	a_tristate_idle:     assert property (!read_active |=> bus.en_n) else $error("bus driven idle"); // RL18
	a_full_word:         assert property (read_active && !host.byte_high && !latch_now |=>
		!bus.en_n && bus.parallel_data_out == result) else $error("word mismatch"); // RL6
	a_upper_byte:        assert property (read_active && host.byte_high && !latch_now |=>
		bus.parallel_data_out[7:0] == result[15:8]) else $error("upper byte mismatch"); // RL7
	a_result_stable:     assert property (!latch_now |=> $stable(result)) else $error("result moved"); // RL23
	a_twos_code:         assert property (latch_now |=> result[15] == ~capacitive_dac[15])
		else $error("bad code format"); // RL22

	c_conversion: cover property (conv_begin ##[1:300] latch_now);
	c_word_read:  cover property (latch_now ##[1:50] (read_active && !host.byte_high));
	c_byte_read:  cover property ((read_active && !host.byte_high) ##[1:20] (read_active && host.byte_high));
	c_ignored:    cover property (busy && start_fall);

endmodule : sar_adc_ctrl

// *** bench/analog_front_model.sv ***
// Analog front end model: comparator against a fixed input level during hold
module analog_front_model (
	// Clock
	input  wire logic        clk,
	// Converter side
	input  wire logic [15:0] capacitive_dac,
	input  wire logic        hold_mode,
	// Input level as a two's complement code
	input  wire logic [15:0] level,
	// Comparator
	output logic             comparator_high
);
	timeunit 1ns;
	timeprecision 1ps;

	logic        noise = 1'b0;
	wire  [15:0] level_offset = level ^ 16'h8000;

	always @(posedge clk)
		noise <= ~noise;

	// Outside hold nothing is sampled, so the comparator output is worthless and keeps changing
	assign comparator_high = hold_mode ? (level_offset >= capacitive_dac) : noise;
endmodule : analog_front_model

// *** bench/sar_adc_convert_and_parallel_read_bench.sv ***
// Self-checking bench for conversion control, busy timing and parallel read-out
module sar_adc_convert_and_parallel_read_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import adc_conv_pkg::*;

	logic        clk = 1'b0;
	logic        reset_n;
	logic        conv_clk;
	int          conv_div;
	host_ctrl_s  host;
	logic        comparator_high;
	logic [15:0] capacitive_dac;
	logic        hold_mode;
	logic        busy;
	logic        acq_ready;
	data_bus_s   bus;
	logic [15:0] target;
	logic [15:0] lfsr;
	logic [15:0] last_result;
	logic [15:0] codes [4] = '{16'h7fff, 16'h8000, 16'hffff, 16'h0000};
	logic        prev_en_n;
	int          busy_len;
	int          cycles;
	int          bad_count;
	int          n_compared;
	logic [15:0] read_q [$];
	int          len_q [$];

	sar_adc_ctrl DUT (
		.clk             (clk),
		.reset_n         (reset_n),
		.conv_clk        (conv_clk),
		.host            (host),
		.comparator_high (comparator_high),
		.capacitive_dac  (capacitive_dac),
		.hold_mode       (hold_mode),
		.busy            (busy),
		.acq_ready       (acq_ready),
		.bus             (bus)
	);

	analog_front_model front (
		.clk             (clk),
		.capacitive_dac  (capacitive_dac),
		.hold_mode       (hold_mode),
		.level           (target),
		.comparator_high (comparator_high)
	);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next

	task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check16

	task automatic check1(input string what, input logic exp, input logic got);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask : check1

	task automatic results;
		if (bad_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	// Strobe held four cycles, released two, as the host timing asks
	task automatic do_read(input logic upper, input logic [15:0] word);
		host.byte_high = upper;
		read_q.push_back(upper ? {8'h00, word[15:8]} : word);
		@(negedge clk);
		host.read_n = 1'b0;
		repeat (4) @(negedge clk);
		host.read_n = 1'b1;
		repeat (2) @(negedge clk);
	endtask : do_read

	task automatic convert(input logic glitch);
		int n;
		repeat (13) @(negedge clk);
		host.conversion_start_n = 1'b0;
		len_q.push_back(CONVERT_CLKS * 10);
		repeat (2) @(negedge clk);
		check1("hold_mode", 1'b1, hold_mode);
		n = 0;
		while (busy !== 1'b1 && n < 12)
		begin
			@(negedge clk);
			n++;
		end
		check1("busy_rise", 1'b1, busy);
		do_read(1'b0, last_result);
		check1("busy_read", 1'b1, busy);
		if (glitch)
		begin
			host.conversion_start_n = 1'b1;
			repeat (3) @(negedge clk);
			host.conversion_start_n = 1'b0;
		end
		n = 0;
		while (busy !== 1'b0 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		check1("busy_fall", 1'b0, busy);
		check16("capacitive_dac", target ^ 16'h8000, capacitive_dac);
		check1("acq_ready", 1'b0, acq_ready);
		last_result = target;
		repeat (45) @(negedge clk);
		check1("hold_idle", 1'b0, hold_mode);
		check1("acq_ready", 1'b1, acq_ready);
		check1("no_restart", 1'b0, busy);
		do_read(1'b0, target);
		do_read(1'b1, target);
		do_read(1'b0, target);
		host.conversion_start_n = 1'b1;
	endtask : convert

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		forever #5 clk = ~clk;
	end

	// Conversion clock at 10 MHz, 50 ns per phase
	always @(negedge clk)
	begin
		conv_div <= (conv_div == 4) ? 0 : conv_div + 1;
		if (conv_div == 4)
			conv_clk <= ~conv_clk;
	end

	// Output watcher: each fresh read and each busy pulse retires the oldest note
	always @(negedge clk)
	begin
		cycles++;
		if (reset_n === 1'b1 && bus.en_n === 1'b0 && prev_en_n === 1'b1)
			check16("data", read_q.size() ? read_q.pop_front() : 16'hxxxx, bus.parallel_data_out);
		prev_en_n = bus.en_n;
		if (busy === 1'b1)
			busy_len++;
		else if (busy_len > 0)
		begin
			check16("busy_cycles", len_q.size() ? 16'(len_q.pop_front()) : 16'hxxxx, 16'(busy_len));
			busy_len = 0;
		end
		if (cycles > 5000)
		begin
			bad_count++;
			results();
		end
	end

	initial
	begin
		host = '{conversion_start_n: 1'b1, chip_select_n: 1'b1, read_n: 1'b1, byte_high: 1'b0};
		reset_n = 1'b0;
		conv_clk = 1'b0;
		conv_div = 0;
		target = 16'h0000;
		lfsr = 16'h174f;
		last_result = RESULT_RESET;
		prev_en_n = 1'b1;
		busy_len = 0;
		cycles = 0;
		bad_count = 0;
		n_compared = 0;
		repeat (6) @(negedge clk);
		reset_n = 1'b1;
		repeat (2) @(negedge clk);
		check1("busy_init", 1'b0, busy);
		check1("en_n_idle", 1'b1, bus.en_n);
		host.conversion_start_n = 1'b0;
		repeat (15) @(negedge clk);
		check1("hold_unselected", 1'b0, hold_mode);
		check1("busy_unselected", 1'b0, busy);
		host.conversion_start_n = 1'b1;
		host.read_n = 1'b0;
		repeat (3) @(negedge clk);
		check1("en_n_unselected", 1'b1, bus.en_n);
		host.read_n = 1'b1;
		@(negedge clk);
		host.chip_select_n = 1'b0;
		do_read(1'b0, RESULT_RESET);
		for (int i = 0; i < 7; i++)
		begin
			if (i < 4)
				target = codes[i];
			else
			begin
				lfsr = lfsr_next(lfsr);
				target = lfsr;
			end
			convert(i % 2 == 1);
		end
		repeat (5) @(negedge clk);
		results();
	end
endmodule : sar_adc_convert_and_parallel_read_bench
